// >>> rtl/smcr_consts.svh
// constants for the synthesizer main control register block
`ifndef SMCR_CONSTS_SVH
`define SMCR_CONSTS_SVH

`define SMCR_IDX_W        7
`define SMCR_IDX_MAIN     7'h00
`define SMCR_IDX_STATUS   7'h73
`define SMCR_REG_W        16
`define SMCR_MAIN_RST     16'h200c
`define SMCR_BIT_PSYNC    14
`define SMCR_BIT_MUTE     9
`define SMCR_BIT_SPD_HI   8
`define SMCR_BIT_SPD_LO   7
`define SMCR_BIT_CAL      3
`define SMCR_BIT_OSEL     2
`define SMCR_BIT_RESET    1
`define SMCR_BIT_SLEEP    0
`define SMCR_ST_CAL_BUSY  0
`define SMCR_ST_LOCK      1
`define SMCR_ST_IN_RESET  2

`endif

// >>> rtl/smcr_pkg.sv
// types for the synthesizer main control register block
`default_nettype none
package smcr_pkg;
	typedef enum logic [0:0]
	{
		SMCR_PH_IDLE = 1'b0,
		SMCR_PH_DATA = 1'b1
	} smcr_phase_t;
	typedef logic [15:0] smcr_word_t;
endpackage : smcr_pkg
`default_nettype wire

// >>> rtl/smcr_regbus_if.sv
// register access path between the bus slave and the register bank
`timescale 1ns/1ps
`default_nettype none
interface smcr_regbus_if;
	logic        wr;
	logic [6:0]  wr_idx;
	logic [15:0] wr_data;
	logic [6:0]  rd_idx;
	logic [15:0] rd_data;
	modport slave (output wr, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport regs  (input wr, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : smcr_regbus_if
`default_nettype wire

// >>> rtl/smcr_ahb_slave.sv
// zero-wait AHB-Lite slave feeding the register bank
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.svh"
module smcr_ahb_slave
	import smcr_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	smcr_regbus_if.slave     bus
);
	smcr_phase_t             phase_q;
	logic                    wr_pend_q;
	logic [`SMCR_IDX_W-1:0]  idx_q;
	logic [31:0]             hrdata_q;
	logic                    take;

	// only word accesses are issued, so size is not decoded
	assign take        = i_hsel && i_htrans[1] && i_hready;
	assign bus.rd_idx  = i_haddr[`SMCR_IDX_W+1:2];
	assign bus.wr      = (phase_q == SMCR_PH_DATA) && wr_pend_q;
	assign bus.wr_idx  = idx_q;
	assign bus.wr_data = i_hwdata[`SMCR_REG_W-1:0];
	assign o_hrdata    = hrdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			phase_q   <= SMCR_PH_IDLE;
			wr_pend_q <= 1'b0;
			idx_q     <= '0;
		end
		else
		begin
			phase_q   <= take ? SMCR_PH_DATA : SMCR_PH_IDLE;
			wr_pend_q <= take && i_hwrite;
			if (take)
				idx_q <= i_haddr[`SMCR_IDX_W+1:2];
		end
	end

	// read data latched at the address edge so it stands through the data phase
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			hrdata_q <= 32'h0000_0000;
		else if (take && !i_hwrite)
			hrdata_q <= {16'h0000, bus.rd_data};
	end
endmodule : smcr_ahb_slave
`default_nettype wire

// >>> rtl/smcr_main_ctrl.sv
// synthesizer main control register with its control outputs
`timescale 1ns/1ps
`default_nettype none
`include "smcr_consts.svh"
module smcr_main_ctrl
	import smcr_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_cal_busy,
	input  wire logic        i_lock_detect,
	input  wire logic        i_readback_data,
	output logic             o_phase_sync_enable,
	output logic             o_sync_pulse,
	output logic             o_rf_output_first_mute,
	output logic             o_rf_output_second_mute,
	output logic [1:0]       o_calibration_pd_speed,
	output logic             o_calibration_trigger,
	output logic             o_multiplexed_output_pin,
	output logic             o_device_reset,
	output logic             o_device_sleep
);
	smcr_regbus_if           rbus ();
	smcr_word_t              main_q;
	smcr_word_t              main_d;
	logic                    main_wr;
	logic                    leave_reset;
	logic                    sync_q;
	logic                    cal_q;
	logic                    mux_q;
	logic                    mute_q;

	////////////////////////////////////////////////////////////////////////////
	smcr_ahb_slave u_slave
	(
		.i_mclk      (i_mclk),
		.i_rstn      (i_rstn),
		.i_hsel      (i_hsel),
		.i_haddr     (i_haddr),
		.i_htrans    (i_htrans),
		.i_hwrite    (i_hwrite),
		.i_hsize     (i_hsize),
		.i_hwdata    (i_hwdata),
		.i_hready    (i_hready),
		.o_hrdata    (o_hrdata),
		.o_hreadyout (o_hreadyout),
		.o_hresp     (o_hresp),
		.bus         (rbus)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic smcr_word_t read_word(input logic [`SMCR_IDX_W-1:0] idx);
		smcr_word_t v;
		v = '0;
		if (idx == `SMCR_IDX_MAIN)
			v = main_q;
		else if (idx == `SMCR_IDX_STATUS)
		begin
			v[`SMCR_ST_CAL_BUSY] = i_cal_busy;
			v[`SMCR_ST_LOCK]     = i_lock_detect;
			v[`SMCR_ST_IN_RESET] = main_q[`SMCR_BIT_RESET];
		end
		return v;
	endfunction : read_word

	// a read right behind a write to the same word must see the new value
	assign rbus.rd_data = (main_wr && (rbus.rd_idx == `SMCR_IDX_MAIN))
	                      ? main_d
	                      : read_word(rbus.rd_idx);
	assign main_wr      = rbus.wr && (rbus.wr_idx == `SMCR_IDX_MAIN);
	// a reset write still keeps bit 1 so the host sees the block held in reset
	assign main_d       = rbus.wr_data[`SMCR_BIT_RESET]
	                      ? (`SMCR_MAIN_RST | 16'h0002)
	                      : rbus.wr_data;
	assign leave_reset  = !rbus.wr_data[`SMCR_BIT_RESET];

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			main_q <= `SMCR_MAIN_RST;
		else if (main_wr)
			main_q <= main_d;
	end

	// sync pulse only on a rising phase-sync bit, never while held in reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			sync_q <= 1'b0;
		else
			sync_q <= main_wr && leave_reset && rbus.wr_data[`SMCR_BIT_PSYNC]
			          && !main_q[`SMCR_BIT_PSYNC];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			cal_q <= 1'b0;
		else
			cal_q <= main_wr && leave_reset && rbus.wr_data[`SMCR_BIT_CAL];
	end

	// mute follows the calibration busy flag one cycle late while the mute bit (bit 9) is set, to keep it glitch free
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			mute_q <= 1'b0;
		else
			mute_q <= main_q[`SMCR_BIT_MUTE] && i_cal_busy;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			mux_q <= 1'b0;
		else if (main_q[`SMCR_BIT_OSEL])
			mux_q <= i_lock_detect;
		else
			mux_q <= i_readback_data;
	end

	assign o_phase_sync_enable      = main_q[`SMCR_BIT_PSYNC];
	assign o_sync_pulse             = sync_q;
	assign o_rf_output_first_mute   = mute_q;
	assign o_rf_output_second_mute  = mute_q;
	assign o_calibration_pd_speed   = main_q[`SMCR_BIT_SPD_HI:`SMCR_BIT_SPD_LO];
	assign o_calibration_trigger    = cal_q;
	assign o_multiplexed_output_pin = mux_q;
	assign o_device_reset           = main_q[`SMCR_BIT_RESET];
	assign o_device_sleep           = main_q[`SMCR_BIT_SLEEP];

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence s_sync_rise_write;
		main_wr && leave_reset && rbus.wr_data[`SMCR_BIT_PSYNC] && !main_q[`SMCR_BIT_PSYNC];
	endsequence

	sequence s_reset_write;
		main_wr && !leave_reset;
	endsequence

	a_phase_fb_follow: assert property (main_wr && leave_reset && rbus.wr_data[14]
		|=> o_phase_sync_enable)
		else $error("phase sync enable not set after write");

	a_sync_pulse_once: assert property (s_sync_rise_write |=> o_sync_pulse ##1 !o_sync_pulse)
		else $error("sync pulse missing or too long");

	a_sync_no_repeat: assert property (o_sync_pulse |-> $past(main_q[14]) == 1'b0)
		else $error("sync pulse while bit already set");

	a_mute_cal_only: assert property (o_rf_output_first_mute
		|-> $past(main_q[9]) && $past(i_cal_busy))
		else $error("outputs muted without cause");

	a_mute_applies: assert property (main_q[9] && i_cal_busy |=> o_rf_output_second_mute)
		else $error("outputs not muted during calibration");

	a_cal_start: assert property (main_wr && leave_reset && rbus.wr_data[3]
		|=> o_calibration_trigger)
		else $error("calibration not started");

	a_cal_none: assert property (o_calibration_trigger
		|-> $past(main_wr) && $past(leave_reset) && $past(rbus.wr_data[`SMCR_BIT_CAL]))
		else $error("calibration started without write");

	// the first edge out of reset still shows the reset value of the pin
	a_pin_select: assert property ($past(i_rstn) |-> o_multiplexed_output_pin ==
		($past(main_q[`SMCR_BIT_OSEL]) ? $past(i_lock_detect) : $past(i_readback_data)))
		else $error("mux pin shows wrong source");

	a_reset_default: assert property (s_reset_write |=> main_q == 16'h200e
		##1 (o_device_reset || $past(main_wr)))
		else $error("reset write did not load defaults");

	a_reset_value: assert property ($rose(i_rstn) |-> main_q == 16'h200c)
		else $error("wrong value after reset");

	a_sleep_bit: assert property (main_wr && leave_reset
		|=> o_device_sleep == $past(rbus.wr_data[`SMCR_BIT_SLEEP]))
		else $error("sleep does not follow bit 0");

	a_reset_quiet: assert property (s_reset_write
		|=> !o_calibration_trigger && !o_sync_pulse)
		else $error("pulse issued by a reset write");

	a_reset_holds: assert property (o_device_reset && !(main_wr && leave_reset)
		|=> o_device_reset)
		else $error("reset released without a clearing write");

	a_speed_follow: assert property (main_wr && leave_reset
		|=> o_calibration_pd_speed == $past(rbus.wr_data[`SMCR_BIT_SPD_HI:`SMCR_BIT_SPD_LO]))
		else $error("calibration speed does not follow write");
endmodule : smcr_main_ctrl
`default_nettype wire

// >>> bench/smcr_host_model.sv
// host-side bus master model for the main control register
`timescale 1ns/1ps
`default_nettype none
module smcr_host_model
(
	input  wire logic        i_mclk,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hrdata,
	output logic             o_hsel,
	output logic      [31:0] o_haddr,
	output logic      [1:0]  o_htrans,
	output logic             o_hwrite,
	output logic      [2:0]  o_hsize,
	output logic      [31:0] o_hwdata
);
	initial
	begin
		o_hsel   = 1'b0;
		o_haddr  = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize  = 3'h2;
		o_hwdata = 32'h0;
	end
	////////////////////////////////////////////////////////////////
	// single word transfer, address held until hready, then data
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge i_mclk);
		o_hsel   <= 1'b1;
		o_haddr  <= a;
		o_htrans <= 2'h2;
		o_hwrite <= wr;
		do @(posedge i_mclk); while (i_hready !== 1'b1);
		o_htrans <= 2'h0;
		o_hwdata <= wd;
		do @(posedge i_mclk); while (i_hready !== 1'b1);
		rd = i_hrdata;
	endtask : xfer
	////////////////////////////////////////////////////////////////
	// word the host programs, speed field picked from pd frequency
	function automatic logic [15:0] word_for(input int pd_mhz, input logic [15:0] c);
		logic [1:0] s;
		s = (pd_mhz <= 100) ? 2'h0 : (pd_mhz <= 150) ? 2'h1 : (pd_mhz <= 200) ? 2'h2 : 2'h3;
		return {1'b0, c[14], 4'h8, c[9], s, 3'h1, c[3:0]};
	endfunction : word_for
endmodule : smcr_host_model
`default_nettype wire

// >>> bench/synth_main_control_register_tb.sv
// self-checking testbench for the main control register block
`timescale 1ns/1ps
`default_nettype none
module synth_main_control_register_tb;
	logic i_mclk, i_rstn, cal_busy, lock, rbk, hsel, hwrite, hrdy, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, spd;
	logic [2:0]  hsize;
	logic psync, sync_p, mute_a, mute_b, trig, pin, dev_rst, sleep;
	int failures, num_checks;
	int pd[4] = '{80, 120, 180, 250};
	smcr_main_ctrl uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.i_cal_busy(cal_busy), .i_lock_detect(lock), .i_readback_data(rbk),
		.o_phase_sync_enable(psync), .o_sync_pulse(sync_p), .o_rf_output_first_mute(mute_a),
		.o_rf_output_second_mute(mute_b), .o_calibration_pd_speed(spd),
		.o_calibration_trigger(trig), .o_multiplexed_output_pin(pin),
		.o_device_reset(dev_rst), .o_device_sleep(sleep));
	smcr_host_model host (.i_mclk(i_mclk), .i_hready(hrdy), .i_hrdata(hrdata), .o_hsel(hsel),
		.o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
		.o_hwdata(hwdata));
	always #10 i_mclk = ~i_mclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] d);
		logic [31:0] r;
		host.xfer(1'b1, 32'h0, {16'h0, d}, r);
		#1;
	endtask : wr
	task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		host.xfer(1'b0, a, 32'h0, r);
		chk(what, e, r);
	endtask : rdc
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tick
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial
	begin
		#50000;
		failures++;
		end_of_test();
	end
	initial
	begin
		i_mclk = 1'b0;
		i_rstn = 1'b0;
		cal_busy = 1'b0;
		lock = 1'b1;
		rbk = 1'b0;
		failures = 0;
		num_checks = 0;
		repeat (12) @(posedge i_mclk);
		i_rstn <= 1'b1;
		tick(1);
		rdc("main after reset", 32'h0, 32'h200c);
		chk("pin lock", 1, pin);
		chk("sleep reset", 0, sleep);
		wr(16'h0002);
		chk("reset level", 1, dev_rst);
		chk("reset no cal", 0, trig);
		rdc("main in reset", 32'h0, 32'h200e);
		wr(host.word_for(80, 16'h0000));
		chk("reset cleared", 0, dev_rst);
		chk("no cal", 0, trig);
		for (int s = 0; s < 4; s++)
		begin
			wr(host.word_for(pd[s], 16'h0008));
			chk("cal trigger", 1, trig);
			chk("cal speed", s, spd);
			rdc("main readback", 32'h0, 32'h2018 | (s << 7));
		end
		wr(host.word_for(80, 16'h4000));
		chk("sync pulse", 1, sync_p);
		chk("psync on", 1, psync);
		tick(1);
		chk("sync one cycle", 0, sync_p);
		wr(host.word_for(80, 16'h4000));
		chk("sync rewrite", 0, sync_p);
		wr(host.word_for(80, 16'h0200));
		chk("psync off", 0, psync);
		@(posedge i_mclk);
		cal_busy <= 1'b1;
		tick(2);
		chk("mute a", 1, mute_a);
		chk("mute b", 1, mute_b);
		wr(host.word_for(80, 16'h0000));
		tick(1);
		chk("mute off", 0, mute_a | mute_b);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge i_mclk);
			rbk <= v[0];
			cal_busy <= 1'b0;
			tick(2);
			chk("pin readback", v, pin);
		end
		wr(host.word_for(80, 16'h0004));
		@(posedge i_mclk);
		lock <= 1'b0;
		tick(2);
		chk("pin lock low", 0, pin);
		@(posedge i_mclk);
		lock <= 1'b1;
		wr(host.word_for(80, 16'h0001));
		chk("sleep on", 1, sleep);
		rdc("status", 32'h1cc, 32'h2);
		rdc("unmapped", 32'h100, 32'h0);
		chk("okay", 0, hresp);
		// a reset in mid-run must bring the defaults back
		@(posedge i_mclk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		tick(1);
		rdc("main after rerun", 32'h0, 32'h200c);
		chk("sleep rerun", 0, sleep);
		end_of_test();
	end
endmodule : synth_main_control_register_tb
`default_nettype wire
